/* hw/cts_top.sv */
// Purpose: transmit candidate selection and module disable handling
// Assumes: frame events come from the protocol engine on pclk
// Notes: buffers hold code and id only; payload lives elsewhere
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cts_params.svh"
module cts_top
    import cts_pkg::*;
#(
    parameter int NMB = 16,
    parameter int IW = $clog2(NMB)
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // frame events from protocol engine
    input wire logic rx_active,
    input wire logic intermission,
    input wire logic rx_remote,
    input wire logic [10:0] rx_id,
    // transmit request stream
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [IW-1:0] tx_idx,
    output logic [10:0] tx_id,
    // clock control
    output logic clk_stop_req
);
    typedef struct packed {
        logic module_disable_bit;
        logic frz;
        logic [IW-1:0] last;
        logic freeze_ack;
        logic lp_ack;
        logic [NMB-1:0][3:0] code;
        logic [NMB-1:0][10:0] id;
        logic [31:0] prdata;
        logic rx_prev;
        logic send_pend;
        logic ans_pend;
        logic [IW-1:0] ans_idx;
    } cts_top_s;

    cts_top_s q, d;
    cts_scan_if #(.IW(IW)) sif ();

    logic wr, rd_setup, mb_hit, cfg_hit, stat_hit, cs_wr, frame_start;
    logic run, push_valid, push_ready, send_ok, match_any;
    logic [IW-1:0] mb_idx, push_idx, match_idx;
    logic [NMB-1:0] match;
    logic [31:0] rd_val;

    assign run = !q.module_disable_bit;
    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign cfg_hit = (paddr == `CTS_CFG_OFS);
    assign stat_hit = (paddr == `CTS_STAT_OFS);
    assign mb_hit = (paddr[11:8] == `CTS_MB_REGION) && (paddr[1:0] == 2'b00)
        && ({1'b0, paddr[7:3]} < 6'(NMB));
    assign mb_idx = paddr[3 +: IW];
    assign cs_wr = wr && mb_hit && !paddr[2];
    assign frame_start = rx_active && !q.rx_prev;

    // remote answer buffers that match the incoming request
    genvar gi;
    generate
        for (gi = 0; gi < NMB; gi++)
        begin : g_match
            assign match[gi] = (q.code[gi] == CTS_CODE_REM_ANS) &&
                (q.id[gi] == rx_id) && (IW'(gi) <= q.last);
        end
    endgenerate
    assign match_any = |match;

    always_comb
    begin
        match_idx = '0;
        for (int i = NMB - 1; i >= 0; i--)
            if (match[i])
                match_idx = IW'(i);
    end

    // send: remote answer first, otherwise the scan winner if still armed
    assign send_ok = q.send_pend && run && !sif.busy;
    assign push_idx = q.ans_pend ? q.ans_idx : sif.win_idx;
    // an unmatched remote request leaves the scan winner armed
    assign push_valid = send_ok && (q.ans_pend ||
        (sif.win_valid && q.code[sif.win_idx] == CTS_CODE_TX_DATA));

    assign sif.last_idx = q.last;
    assign sif.rd_code = q.code[sif.rd_idx];
    assign sif.rd_id = q.id[sif.rd_idx];
    assign sif.start = run && (frame_start || cs_wr ||
        (push_valid && push_ready && !q.ans_pend));

    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (cfg_hit)
        begin
            rd_val[`CTS_MODULE_DISABLE_BIT_POS] = q.module_disable_bit;
            rd_val[`CTS_FRZ_POS] = q.frz;
            rd_val[`CTS_LAST_LSB +: IW] = q.last;
        end
        else if (stat_hit)
        begin
            rd_val[`CTS_FRZACK_POS] = q.freeze_ack;
            rd_val[`CTS_LPACK_POS] = q.lp_ack;
            rd_val[`CTS_WINV_POS] = sif.win_valid;
            rd_val[`CTS_BUSY_POS] = sif.busy;
            rd_val[`CTS_WIN_LSB +: IW] = sif.win_idx;
        end
        else if (mb_hit && !paddr[2])
            rd_val[`CTS_CODE_LSB +: 4] = q.code[mb_idx];
        else if (mb_hit)
            rd_val[`CTS_ID_W-1:0] = q.id[mb_idx];
    end

    always_comb
    begin
        d = q;
        d.rx_prev = rx_active;
        if (rd_setup)
            d.prdata = rd_val;
        if (wr && cfg_hit)
        begin
            d.module_disable_bit = pwdata[`CTS_MODULE_DISABLE_BIT_POS];
            d.frz = pwdata[`CTS_FRZ_POS];
            d.last = pwdata[`CTS_LAST_LSB +: IW];
        end
        if (cs_wr)
            d.code[mb_idx] = pwdata[`CTS_CODE_LSB +: 4];
        if (wr && mb_hit && paddr[2])
            d.id[mb_idx] = pwdata[`CTS_ID_W-1:0];
        // disable takes precedence over freeze acknowledge
        d.lp_ack = q.module_disable_bit;
        d.freeze_ack = q.frz && !q.module_disable_bit;
        if (send_ok && (!push_valid || push_ready))
        begin
            d.send_pend = 1'b0;
            if (q.ans_pend)
                d.ans_pend = 1'b0;
            else if (push_valid)
                d.code[sif.win_idx] = CTS_CODE_INACTIVE;
        end
        // a new event in the cycle of a send wins over the clear
        if (intermission && run)
            d.send_pend = 1'b1;
        if (rx_remote && run && match_any)
        begin
            d.ans_pend = 1'b1;
            d.ans_idx = match_idx;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.last <= IW'(`CTS_LAST_RST);
        end
        else if (clk_en)
            q <= d;
    end

    cts_scan #(.IW(IW)) u_scan (
        .pclk(pclk),
        .presetn(presetn),
        .en(clk_en && run),
        .sif(sif)
    );

    cts_buf #(.W(IW + 11)) u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data({push_idx, q.id[push_idx]}),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data({tx_idx, tx_id})
    );

    assign prdata = q.prdata;
    assign pready = psel && penable;
    assign pslverr = pready && !(cfg_hit || stat_hit || mb_hit);
    assign clk_stop_req = q.module_disable_bit;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_frame_open;
        clk_en && run && frame_start;
    endsequence

    sequence s_scanning;
        sif.busy [*2];
    endsequence

    scan_on_rx_a: assert property (s_frame_open |=> s_scanning)
        else $error("no scan during frame reception");
    new_frame_a: assert property (clk_en && run && frame_start && !sif.busy |=> sif.busy)
        else $error("new frame did not restart scan");
    cs_rescan_a: assert property (clk_en && run && cs_wr |=> sif.busy)
        else $error("control word write did not rescan");
    remote_ans_a: assert property (clk_en && run && rx_remote && match_any |=> q.ans_pend && q.ans_idx == $past(match_idx))
        else $error("remote answer not armed");
    keep_win_a: assert property (clk_en && run && rx_remote && !match_any && !q.ans_pend && !send_ok |=> !q.ans_pend && $stable(sif.win_valid))
        else $error("unmatched remote request dropped candidate");
    send_arm_a: assert property (clk_en && run && intermission && !send_ok |=> q.send_pend)
        else $error("intermission did not arm send");
    stop_req_a: assert property (clk_en && $rose(q.module_disable_bit) |-> clk_stop_req ##1 (!clk_en || q.lp_ack))
        else $error("disable without clock stop request");
    frz_swap_a: assert property (clk_en && q.module_disable_bit && q.freeze_ack |=> !q.freeze_ack && q.lp_ack && clk_stop_req)
        else $error("freeze ack not swapped on disable");
endmodule : cts_top
`default_nettype wire

/* hw/cts_params.svh */
// Purpose: offsets, field positions and reset values of the tx select block
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:
// Overview of operation
// - scan stops at the last buffer index
// - remote answer buffer replies to matching request
// - scan transmit buffers while a frame is received
// - candidate chosen by the intermission field
// - unmatched remote request keeps the chosen candidate
// - control word write restarts candidate selection
// - new frame start restarts candidate scan
// - disable bit enters low-power disable mode
// - disabled: request external clock stop, no gating
// - disable in freeze: stop request, ack flags swap
`ifndef CTS_PARAMS_SVH
`define CTS_PARAMS_SVH

`define CTS_CFG_OFS 12'h000
`define CTS_STAT_OFS 12'h004
`define CTS_MB_REGION 4'h1
`define CTS_MODULE_DISABLE_BIT_POS 31
`define CTS_FRZ_POS 30
`define CTS_LAST_LSB 0
`define CTS_LAST_RST 4'hF
`define CTS_FRZACK_POS 0
`define CTS_LPACK_POS 1
`define CTS_WINV_POS 8
`define CTS_BUSY_POS 9
`define CTS_WIN_LSB 16
`define CTS_CODE_LSB 24
`define CTS_ID_W 11

`endif

/* hw/cts_pkg.sv */
// Purpose: types of the tx select block
// Assumes: cts_params.svh included first
// Notes: buffer codes follow the control word code field
package cts_pkg;
    typedef enum logic [3:0]
    {
        CTS_CODE_RX_EMPTY = 4'h4,
        CTS_CODE_INACTIVE = 4'h8,
        CTS_CODE_REM_ANS = 4'hA,
        CTS_CODE_TX_DATA = 4'hC
    } cts_code_e;
    typedef enum logic [1:0]
    {
        CTS_ST_IDLE = 2'h0,
        CTS_ST_SCAN = 2'h1,
        CTS_ST_DONE = 2'h3
    } cts_state_e;
    typedef logic [10:0] cts_id_t;
endpackage : cts_pkg

/* hw/cts_scan_if.sv */
// Purpose: link between register core and the candidate scanner
// Assumes: one clock domain
// Notes: scanner reads one buffer per cycle through rd_idx
`timescale 1ns/1ps
`default_nettype none
interface cts_scan_if #(parameter int IW = 4);
    logic start;
    logic [IW-1:0] last_idx;
    logic [IW-1:0] rd_idx;
    logic [3:0] rd_code;
    logic [10:0] rd_id;
    logic win_valid;
    logic [IW-1:0] win_idx;
    logic busy;
    modport scan (input start, last_idx, rd_code, rd_id,
                  output rd_idx, win_valid, win_idx, busy);
    modport core (output start, last_idx, rd_code, rd_id,
                  input rd_idx, win_valid, win_idx, busy);
endinterface : cts_scan_if
`default_nettype wire

/* hw/cts_scan.sv */
// Purpose: walk transmit buffers and keep the lowest-id candidate
// Assumes: start is a one-cycle pulse; en freezes everything
// Notes: the previous winner stands until a scan completes
`timescale 1ns/1ps
`default_nettype none
module cts_scan
    import cts_pkg::*;
#(
    parameter int IW = 4
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    // core side
    cts_scan_if.scan sif
);
    typedef struct packed {
        cts_state_e st;
        logic [IW-1:0] idx;
        logic found;
        logic [IW-1:0] best;
        cts_id_t best_id;
        logic win_valid;
        logic [IW-1:0] win_idx;
    } cts_scan_s;

    cts_scan_s q, d;

    always_comb
    begin
        d = q;
        case (q.st)
            CTS_ST_IDLE:
            begin
                if (sif.start)
                begin
                    d.st = CTS_ST_SCAN;
                    d.idx = '0;
                    d.found = 1'b0;
                end
            end
            CTS_ST_SCAN:
            begin
                if (sif.rd_code == CTS_CODE_TX_DATA &&
                    (!q.found || sif.rd_id < q.best_id))
                begin
                    d.found = 1'b1;
                    d.best = q.idx;
                    d.best_id = sif.rd_id;
                end
                if (q.idx == sif.last_idx)
                    d.st = CTS_ST_DONE;
                else
                    d.idx = q.idx + 1'b1;
                if (sif.start)
                begin
                    d.st = CTS_ST_SCAN;
                    d.idx = '0;
                    d.found = 1'b0;
                end
            end
            CTS_ST_DONE:
            begin
                d.win_valid = q.found;
                d.win_idx = q.best;
                d.st = sif.start ? CTS_ST_SCAN : CTS_ST_IDLE;
                d.idx = '0;
                d.found = 1'b0;
            end
            default:
                d.st = CTS_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else if (en)
            q <= d;
    end

    assign sif.rd_idx = q.idx;
    assign sif.win_valid = q.win_valid;
    assign sif.win_idx = q.win_idx;
    assign sif.busy = (q.st != CTS_ST_IDLE);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    last_stop_a: assert property (en && q.st == CTS_ST_SCAN && !sif.start && q.idx == sif.last_idx |=> q.st == CTS_ST_DONE)
        else $error("scan did not stop at last index");
endmodule : cts_scan
`default_nettype wire

/* hw/cts_buf.sv */
// Purpose: two-entry buffer on the transmit request path
// Assumes: same clock on both sides
// Notes: in_ready low only when both entries hold data
`timescale 1ns/1ps
`default_nettype none
module cts_buf
    import cts_pkg::*;
#(
    parameter int W = 15
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [1:0][W-1:0] ent;
        logic [1:0] cnt;
    } cts_buf_s;

    cts_buf_s q, d;
    logic push, pop;

    assign in_ready = (q.cnt != 2'd2);
    assign out_valid = (q.cnt != 2'd0);
    assign out_data = q.ent[0];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        d = q;
        if (pop)
            d.ent[0] = q.ent[1];
        if (push)
            d.ent[q.cnt - (pop ? 2'd1 : 2'd0)] = in_data;
        d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else if (clk_en)
            q <= d;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    buf_full_a: assert property (clk_en && q.cnt == 2'd1 && push && !pop |=> !in_ready && out_valid)
        else $error("buffer full not reported");
endmodule : cts_buf
`default_nettype wire

/* sim/cts_peer.sv */
// Purpose: far-side model: frame events from the bus and the tx sink
// Assumes: one clock; events launched just after a rising edge
// Notes: rx_id carries inverted junk outside the last cycle of a frame
`timescale 1ns/1ps
`default_nettype none
module cts_peer
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // frame events
    output logic rx_active,
    output logic intermission,
    output logic rx_remote,
    output logic [10:0] rx_id,
    // transmit sink
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [3:0] tx_idx,
    input wire logic [10:0] tx_id,
    // clock control
    input wire logic clk_stop_req,
    output logic sub_clk_on
);
    logic hold = 1'b0;
    logic [1:0] cnt_q;
    logic [14:0] got_q[$];
    initial
    begin
        rx_active = 1'b0;
        intermission = 1'b0;
        rx_remote = 1'b0;
        rx_id = 11'h7FF;
    end
    // sink stalls every other cycle, and fully while hold is set
    assign tx_ready = !hold && cnt_q[0];
    assign sub_clk_on = !clk_stop_req;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 2'h0;
        else
            cnt_q <= cnt_q + 2'h1;
        if (presetn && tx_valid && tx_ready)
            got_q.push_back({tx_idx, tx_id});
    end
    task automatic ifs();
        @(posedge pclk);
        intermission <= 1'b1;
        @(posedge pclk);
        intermission <= 1'b0;
    endtask : ifs
    task automatic frame(input logic rem, input logic [10:0] id, input int len);
        @(posedge pclk);
        rx_active <= 1'b1;
        repeat (len) @(posedge pclk);
        rx_remote <= rem;
        rx_id <= id;
        @(posedge pclk);
        rx_remote <= 1'b0;
        rx_id <= ~id;
        rx_active <= 1'b0;
        ifs();
    endtask : frame
endmodule : cts_peer
`default_nettype wire

/* sim/can_tx_select_and_module_disable_tb.sv */
// Purpose: register-level tests of tx selection and module disable
// Assumes: zero-wait APB slave, frames longer than NMB+3 cycles
// Notes: expectations follow lowest id wins among tx buffers
`timescale 1ns/1ps
`default_nettype none
module can_tx_select_and_module_disable_tb
    import cts_pkg::*;
;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic rx_active, intermission, rx_remote, tx_valid, tx_ready;
    logic clk_stop_req, sub_clk_on, rerr;
    logic [10:0] rx_id, tx_id;
    logic [3:0] tx_idx;
    int n_errors = 0;
    int checked = 0;
    cts_top #(.NMB(16)) cts_top_inst (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_active(rx_active),
        .intermission(intermission), .rx_remote(rx_remote), .rx_id(rx_id),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_idx(tx_idx),
        .tx_id(tx_id), .clk_stop_req(clk_stop_req));
    cts_peer cts_peer_inst (.pclk(pclk), .presetn(presetn),
        .rx_active(rx_active), .intermission(intermission),
        .rx_remote(rx_remote), .rx_id(rx_id), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_idx(tx_idx), .tx_id(tx_id),
        .clk_stop_req(clk_stop_req), .sub_clk_on(sub_clk_on));
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            n_errors++;
            conclude();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat & m);
    endtask : rdc
    task automatic setmb(input int n, input cts_code_e c, input logic [10:0] id);
        apb(1'b1, 12'h104 + 12'(n * 8), {21'h0, id});
        apb(1'b1, 12'h100 + 12'(n * 8), {4'h0, c, 24'h0});
    endtask : setmb
    task automatic exp_tx(input string nm, input logic [3:0] i, input logic [10:0] id);
        int n;
        n = 0;
        while (cts_peer_inst.got_q.size() == 0 && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 300)
        begin
            n_errors++;
            conclude();
        end
        chk(nm, {17'h0, i, id}, {17'h0, cts_peer_inst.got_q.pop_front()});
    endtask : exp_tx
    initial
    begin
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc("cfg reset", 12'h000, 32'hFFFFFFFF, 32'h0000000F);
        rdc("unmapped data", 12'h0F0, 32'hFFFFFFFF, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        apb(1'b1, 12'h000, 32'h00000007);
        setmb(2, CTS_CODE_TX_DATA, 11'h100);
        setmb(5, CTS_CODE_TX_DATA, 11'h050);
        setmb(9, CTS_CODE_TX_DATA, 11'h001);
        setmb(7, CTS_CODE_REM_ANS, 11'h077);
        cts_peer_inst.frame(1'b0, 11'h000, 24);
        exp_tx("winner in range", 4'h5, 11'h050);
        rdc("sent code", 12'h128, 32'h0F000000, 32'h08000000);
        // sink blocked: both sends must wait in the buffer
        cts_peer_inst.hold <= 1'b1;
        cts_peer_inst.frame(1'b1, 11'h033, 24);
        cts_peer_inst.frame(1'b1, 11'h077, 24);
        cts_peer_inst.hold <= 1'b0;
        exp_tx("unmatched remote", 4'h2, 11'h100);
        exp_tx("remote answer", 4'h7, 11'h077);
        rdc("answer code kept", 12'h138, 32'h0F000000, 32'h0A000000);
        setmb(3, CTS_CODE_TX_DATA, 11'h020);
        repeat (20) @(posedge pclk);
        cts_peer_inst.ifs();
        exp_tx("cs rescan", 4'h3, 11'h020);
        apb(1'b1, 12'h000, 32'h40000007);
        repeat (3) @(posedge pclk);
        rdc("freeze ack", 12'h004, 32'h3, 32'h1);
        chk("no stop in freeze", 32'h0, {31'h0, clk_stop_req});
        apb(1'b1, 12'h000, 32'hC0000007);
        repeat (3) @(posedge pclk);
        chk("stop request", 32'h1, {31'h0, clk_stop_req});
        rdc("ack swap", 12'h004, 32'h3, 32'h2);
        setmb(4, CTS_CODE_TX_DATA, 11'h005);
        cts_peer_inst.frame(1'b0, 11'h000, 24);
        repeat (40) @(posedge pclk);
        chk("no send disabled", 32'h0, 32'(cts_peer_inst.got_q.size()));
        apb(1'b1, 12'h000, 32'h00000007);
        repeat (3) @(posedge pclk);
        chk("stop withdrawn", 32'h0, {31'h0, clk_stop_req});
        cts_peer_inst.frame(1'b0, 11'h000, 24);
        exp_tx("frame rescan", 4'h4, 11'h005);
        conclude();
    end
endmodule : can_tx_select_and_module_disable_tb
`default_nettype wire
